// ===== hdl/pci_core.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Enable turns on controller, holds position
// - Home request starts homing when idle
// - Dropping home request aborts homing, no error
// - Trigger rising edge takes task; falling ignored
// - Homing ignores trigger, pause and hold
// - Relative select adds to current target
// - Relative clear means absolute target
// - Preempt select replaces running move at once
// - Preempt clear queues task after current move
// - Appended move delays target-reached to its end
// - Pause stops axis, move stays pending
// - Pause release resumes; clear lets move finish
// - Hold stops with the move's deceleration
// - After hold, target-reached stays clear
// - Hold release does nothing; no resume
// - Status word sits in bytes 2/3
// - Target-reached only if inside target window
// - Power-stage-active follows controller enabling
module pci_core
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic homing_done,
    input wire logic move_done,
    input wire logic axis_halted,
    input wire logic [31:0] actual_pos,
    output logic [31:0] setpoint,
    output logic drive_enable,
    output logic motion_run,
    output logic decel_stop,
    output logic homing_run,
    output logic [63:0] status_telegram
);
    typedef struct packed
    {
        pci_pkg::pci_state_t fsm;
        logic [63:0] tx;
        logic [31:0] win;
        logic [31:0] cur_tgt;
        logic [31:0] q_tgt;
        logic q_valid;
        logic reached;
        logic home_ok;
        logic held;
        logic commit;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_a;
        logic [31:0] w_d;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [15:0] sw;
    } pci_core_t;

    pci_core_t st_ff;
    pci_core_t nxt_st;
    logic [15:0] cw;
    logic [15:0] pw;
    logic [31:0] tel_tgt;
    logic fresh;
    logic [15:0] rise;
    logic [15:0] fall;
    pci_telegram_in u_tin
    (
        .aclk(aclk), .aresetn(aresetn), .commit(st_ff.commit), .fresh(fresh),
        .telegram(st_ff.tx), .ctrl_word(cw), .prev_word(pw), .target(tel_tgt)
    );
    pci_edge_detect u_edge
    (
        .fresh(fresh), .cur(cw), .prev(pw), .rise(rise), .fall(fall)
    );
    wire logic en = cw[pci_pkg::CW_ENABLE];
    wire logic home_req = cw[pci_pkg::CW_HOME];
    wire logic pause_req = cw[pci_pkg::CW_PAUSE];
    wire logic hold_rise = rise[pci_pkg::CW_HOLD];
    wire logic trig = rise[pci_pkg::CW_TRIG];
    // The selects are read from the same telegram that carries the edge.
    wire logic [31:0] new_tgt = cw[pci_pkg::CW_REL]
        ? st_ff.cur_tgt + tel_tgt : tel_tgt;
    wire logic [31:0] err = actual_pos - st_ff.cur_tgt;
    wire logic in_win = ($signed(err) <= $signed(st_ff.win)) &&
        ($signed(err) >= -$signed(st_ff.win));

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.commit = 1'b0;
        case (st_ff.fsm)
            pci_pkg::ST_OFF:
            begin
                if (en)
                begin
                    nxt_st.cur_tgt = actual_pos;
                    nxt_st.fsm = pci_pkg::ST_IDLE;
                end
            end
            pci_pkg::ST_IDLE:
            begin
                if (home_req && rise[pci_pkg::CW_HOME])
                begin
                    nxt_st.home_ok = 1'b0;
                    nxt_st.reached = 1'b0;
                    nxt_st.fsm = pci_pkg::ST_HOMING;
                end
                else if (trig)
                begin
                    nxt_st.cur_tgt = new_tgt;
                    nxt_st.reached = 1'b0;
                    nxt_st.held = 1'b0;
                    nxt_st.fsm = pci_pkg::ST_MOVING;
                end
            end
            pci_pkg::ST_HOMING:
            begin
                // Trigger, pause and hold are deliberately not looked at.
                if (!home_req)
                begin
                    nxt_st.fsm = pci_pkg::ST_IDLE;
                end
                else if (homing_done)
                begin
                    nxt_st.home_ok = 1'b1;
                    nxt_st.cur_tgt = actual_pos;
                    nxt_st.fsm = pci_pkg::ST_IDLE;
                end
            end
            pci_pkg::ST_MOVING, pci_pkg::ST_PAUSED:
            begin
                if (hold_rise)
                begin
                    nxt_st.q_valid = 1'b0;
                    nxt_st.held = 1'b1;
                    nxt_st.fsm = pci_pkg::ST_STOPPING;
                end
                else if (trig && cw[pci_pkg::CW_PREEMPT])
                begin
                    nxt_st.cur_tgt = new_tgt;
                    nxt_st.q_valid = 1'b0;
                end
                else if (trig)
                begin
                    nxt_st.q_tgt = new_tgt;
                    nxt_st.q_valid = 1'b1;
                end
                else if (st_ff.fsm == pci_pkg::ST_MOVING && pause_req)
                begin
                    nxt_st.fsm = pci_pkg::ST_PAUSED;
                end
                else if (st_ff.fsm == pci_pkg::ST_PAUSED && !pause_req)
                begin
                    nxt_st.fsm = pci_pkg::ST_MOVING;
                end
                else if (st_ff.fsm == pci_pkg::ST_MOVING && move_done)
                begin
                    if (st_ff.q_valid)
                    begin
                        nxt_st.cur_tgt = st_ff.q_tgt;
                        nxt_st.q_valid = 1'b0;
                    end
                    else
                    begin
                        nxt_st.reached = in_win;
                        nxt_st.fsm = pci_pkg::ST_IDLE;
                    end
                end
            end
            pci_pkg::ST_STOPPING:
            begin
                // Releasing hold is not watched; only standstill or dropping enable ends this.
                if (axis_halted)
                begin
                    nxt_st.cur_tgt = actual_pos;
                    nxt_st.reached = 1'b0;
                    nxt_st.fsm = pci_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_st.fsm = pci_pkg::ST_OFF;
            end
        endcase
        if (!en)
        begin
            nxt_st.fsm = pci_pkg::ST_OFF;
            nxt_st.q_valid = 1'b0;
            nxt_st.reached = 1'b0;
        end
        nxt_st.sw = '0;
        nxt_st.sw[pci_pkg::SW_POWER] = nxt_st.fsm != pci_pkg::ST_OFF;
        nxt_st.sw[pci_pkg::SW_HOMING] = nxt_st.fsm == pci_pkg::ST_HOMING;
        nxt_st.sw[pci_pkg::SW_MOVING] = nxt_st.fsm == pci_pkg::ST_MOVING;
        nxt_st.sw[pci_pkg::SW_TARGET] = nxt_st.reached;
        nxt_st.sw[pci_pkg::SW_QUEUED] = nxt_st.q_valid;
        nxt_st.sw[pci_pkg::SW_PAUSED] = nxt_st.fsm == pci_pkg::ST_PAUSED;
        nxt_st.sw[pci_pkg::SW_HELD] = nxt_st.held;
        nxt_st.sw[pci_pkg::SW_HOME_OK] = nxt_st.home_ok;
        // AXI4-Lite write: address and data accepted in either order.
        if (s_axi_awvalid && !st_ff.aw_got && !st_ff.bv)
        begin
            nxt_st.aw_got = 1'b1;
            nxt_st.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.w_got && !st_ff.bv)
        begin
            nxt_st.w_got = 1'b1;
            nxt_st.w_d = s_axi_wdata;
        end
        if (st_ff.aw_got && st_ff.w_got)
        begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bv = 1'b1;
            nxt_st.br = pci_pkg::RESP_OKAY;
            case (st_ff.aw_a)
                pci_pkg::ADDR_WINDOW: nxt_st.win = st_ff.w_d;
                pci_pkg::ADDR_TX_LO: nxt_st.tx[31:0] = st_ff.w_d;
                pci_pkg::ADDR_TX_HI: nxt_st.tx[63:32] = st_ff.w_d;
                // Commit hands the staged halves over as one telegram.
                pci_pkg::ADDR_CTRL: nxt_st.commit = st_ff.w_d[0];
                default: nxt_st.br = pci_pkg::RESP_SLVERR;
            endcase
        end
        if (st_ff.bv && s_axi_bready)
        begin
            nxt_st.bv = 1'b0;
        end
        if (s_axi_arvalid && !st_ff.rv)
        begin
            nxt_st.rv = 1'b1;
            nxt_st.rr = pci_pkg::RESP_OKAY;
            case (s_axi_araddr)
                pci_pkg::ADDR_STATUS: nxt_st.rd = {16'h0000, st_ff.sw};
                pci_pkg::ADDR_TARGET: nxt_st.rd = st_ff.cur_tgt;
                pci_pkg::ADDR_CMD_POS: nxt_st.rd = tel_tgt;
                pci_pkg::ADDR_WINDOW: nxt_st.rd = st_ff.win;
                pci_pkg::ADDR_TX_LO: nxt_st.rd = st_ff.tx[31:0];
                pci_pkg::ADDR_TX_HI: nxt_st.rd = st_ff.tx[63:32];
                pci_pkg::ADDR_CTRL: nxt_st.rd = {16'h0000, cw};
                default:
                begin
                    nxt_st.rd = pci_pkg::RST_WORD;
                    nxt_st.rr = pci_pkg::RESP_SLVERR;
                end
            endcase
        end
        else if (st_ff.rv && s_axi_rready)
        begin
            nxt_st.rv = 1'b0;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
            st_ff.win <= pci_pkg::RST_WINDOW;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
    assign s_axi_awready = !st_ff.aw_got && !st_ff.bv;
    assign s_axi_wready = !st_ff.w_got && !st_ff.bv;
    assign s_axi_bvalid = st_ff.bv;
    assign s_axi_bresp = st_ff.br;
    assign s_axi_arready = !st_ff.rv;
    assign s_axi_rvalid = st_ff.rv;
    assign s_axi_rdata = st_ff.rd;
    assign s_axi_rresp = st_ff.rr;
    assign setpoint = st_ff.cur_tgt;
    assign drive_enable = st_ff.fsm != pci_pkg::ST_OFF;
    assign motion_run = st_ff.fsm == pci_pkg::ST_MOVING;
    assign decel_stop = st_ff.fsm == pci_pkg::ST_STOPPING;
    assign homing_run = st_ff.fsm == pci_pkg::ST_HOMING;
    // Status word goes out in bytes 2/3 of the returned telegram.
    assign status_telegram = {32'h0000_0000, st_ff.sw, 16'h0000};
    a_homing_aborts: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_HOMING && en && !home_req)
        |=> st_ff.fsm == pci_pkg::ST_IDLE)
        else $error("homing not aborted");
    a_homing_ignores: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_HOMING) |=> $stable(st_ff.cur_tgt)
        || $past(homing_done))
        else $error("target changed during homing");
    a_pause_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_MOVING && en && pause_req && !trig
        && !hold_rise) |=> st_ff.fsm == pci_pkg::ST_PAUSED)
        else $error("pause not taken");
    a_hold_no_reach: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_STOPPING) |=> !st_ff.reached)
        else $error("target reached after hold");
    a_queue_delays: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_MOVING && st_ff.q_valid && move_done)
        |=> !st_ff.reached)
        else $error("reached at end of first move");
    a_reach_window: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(st_ff.reached) |-> $past(in_win))
        else $error("reached outside window");
    a_power_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        st_ff.sw[pci_pkg::SW_POWER] == drive_enable)
        else $error("power flag mismatch");
    a_abs_target: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_ff.fsm == pci_pkg::ST_IDLE && en && trig && !cw[pci_pkg::CW_REL]
        && !rise[pci_pkg::CW_HOME]) |=> st_ff.cur_tgt == $past(tel_tgt))
        else $error("absolute target wrong");
endmodule : pci_core

`default_nettype wire

// ===== common/pci_pkg.sv
package pci_pkg;

    // Control word bit positions (bytes 2/3 of the output telegram).
    localparam int CW_ENABLE = 0;
    localparam int CW_HOME = 1;
    localparam int CW_TRIG = 2;
    localparam int CW_REL = 3;
    localparam int CW_PREEMPT = 4;
    localparam int CW_PAUSE = 5;
    localparam int CW_HOLD = 6;

    // Status word bit positions (bytes 2/3 of the actual-value telegram).
    localparam int SW_POWER = 0;
    localparam int SW_HOMING = 1;
    localparam int SW_MOVING = 2;
    localparam int SW_TARGET = 3;
    localparam int SW_QUEUED = 4;
    localparam int SW_PAUSED = 5;
    localparam int SW_HELD = 6;
    localparam int SW_HOME_OK = 7;

    // Telegram byte lanes holding the control and status words.
    localparam int WORD_LO_BYTE = 2;
    localparam int WORD_HI_BYTE = 3;
    localparam int TELEGRAM_BYTES = 8;

    // AXI4-Lite register map.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TARGET = 8'h08;
    localparam logic [7:0] ADDR_CMD_POS = 8'h0c;
    localparam logic [7:0] ADDR_WINDOW = 8'h10;
    localparam logic [7:0] ADDR_TX_LO = 8'h14;
    localparam logic [7:0] ADDR_TX_HI = 8'h18;

    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RST_WINDOW = 32'h0000_0010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0]
    {
        ST_OFF = 3'h0,
        ST_IDLE = 3'h1,
        ST_HOMING = 3'h2,
        ST_MOVING = 3'h3,
        ST_PAUSED = 3'h4,
        ST_STOPPING = 3'h5
    } pci_state_t;

endpackage : pci_pkg

// ===== hdl/pci_telegram_in.sv
`timescale 1ns/1ns
`default_nettype none

// Latches a whole output telegram on its commit strobe so the control word
// and target are never taken from a half-written telegram.
module pci_telegram_in
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic commit,
    input wire logic [63:0] telegram,
    output logic [15:0] ctrl_word,
    output logic [15:0] prev_word,
    output logic [31:0] target,
    output logic fresh
);
    typedef struct packed
    {
        logic [15:0] cw;
        logic [15:0] pw;
        logic [31:0] tg;
        logic fr;
    } pci_tin_t;

    pci_tin_t st_ff;
    pci_tin_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.fr = 1'b0;
        if (commit)
        begin
            nxt_st.pw = st_ff.cw;
            nxt_st.cw = telegram[8*pci_pkg::WORD_LO_BYTE +: 16];
            nxt_st.tg = telegram[63:32];
            nxt_st.fr = 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign ctrl_word = st_ff.cw;
    assign prev_word = st_ff.pw;
    assign target = st_ff.tg;
    assign fresh = st_ff.fr;

    a_prev_tracks: assert property (@(posedge aclk) disable iff (!aresetn)
        commit |=> prev_word == $past(ctrl_word))
        else $error("previous control word not kept");
endmodule : pci_telegram_in

`default_nettype wire

// ===== hdl/pci_edge_detect.sv
`timescale 1ns/1ns
`default_nettype none

// Combinational per-bit edge finder between two received control words.
module pci_edge_detect
(
    input wire logic fresh,
    input wire logic [15:0] cur,
    input wire logic [15:0] prev,
    output logic [15:0] rise,
    output logic [15:0] fall
);
    genvar i;
    generate
        for (i = 0; i < 16; i++)
        begin : g_bit
            assign rise[i] = fresh & cur[i] & ~prev[i];
            assign fall[i] = fresh & ~cur[i] & prev[i];
        end
    endgenerate
endmodule : pci_edge_detect

`default_nettype wire

// ===== verification/pci_motion_model.sv
`timescale 1ns/1ns
`default_nettype none

// Stands in for the drive's motion control. A paused move keeps its
// elapsed time, while a new setpoint starts the profile over.
module pci_motion_model
#(
    parameter int MOVE_CYC = 100,
    parameter int HOME_CYC = 120
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic motion_run,
    input wire logic homing_run,
    input wire logic decel_stop,
    input wire logic [31:0] setpoint,
    input wire logic [31:0] pos_err,
    output logic move_done,
    output logic homing_done,
    output logic axis_halted,
    output logic [31:0] actual_pos
);
    int mcnt;
    int hcnt;
    int dcnt;
    logic [31:0] last_sp;
    logic fin;

    // The end position shows with the done pulse, so the window check at
    // that pulse sees where the move really ended.
    assign fin = aresetn && motion_run && mcnt == MOVE_CYC;

    always_ff @(posedge aclk)
    begin
        last_sp <= setpoint;
        move_done <= fin;
        homing_done <= aresetn && homing_run && hcnt == HOME_CYC;
        mcnt <= (!aresetn || setpoint != last_sp || move_done) ? 0
            : mcnt + int'(motion_run);
        hcnt <= (!aresetn || !homing_run) ? 0 : hcnt + 1;
        dcnt <= decel_stop ? dcnt + 1 : 0;
        axis_halted <= decel_stop ? dcnt >= 3 : !motion_run;
        actual_pos <= !aresetn ? 32'h0000_0000
            : fin ? setpoint + pos_err : actual_pos;
    end
endmodule : pci_motion_model
`default_nettype wire

// ===== verification/positioning_command_interface_tb.sv
`timescale 1ns/1ns
`default_nettype none

module positioning_command_interface_tb;
    localparam logic [15:0] EN = 16'h0001 << pci_pkg::CW_ENABLE;
    localparam logic [15:0] HOME = 16'h0001 << pci_pkg::CW_HOME;
    localparam logic [15:0] TRIG = 16'h0001 << pci_pkg::CW_TRIG;
    localparam logic [15:0] REL = 16'h0001 << pci_pkg::CW_REL;
    localparam logic [15:0] PRE = 16'h0001 << pci_pkg::CW_PREEMPT;
    localparam logic [15:0] PAUSE = 16'h0001 << pci_pkg::CW_PAUSE;
    localparam logic [15:0] HOLD = 16'h0001 << pci_pkg::CW_HOLD;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, homing_done, move_done;
    logic axis_halted, drive_enable, motion_run, decel_stop, homing_run;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, actual_pos, setpoint, pos_err, rd_data;
    logic [1:0] bresp, rresp, resp;
    logic [63:0] status_telegram;
    int n_fail, check_count;

    pci_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .homing_done(homing_done),
        .move_done(move_done), .axis_halted(axis_halted),
        .actual_pos(actual_pos), .setpoint(setpoint),
        .drive_enable(drive_enable), .motion_run(motion_run),
        .decel_stop(decel_stop), .homing_run(homing_run),
        .status_telegram(status_telegram));

    pci_motion_model motion (.aclk(aclk), .aresetn(aresetn),
        .motion_run(motion_run), .homing_run(homing_run),
        .decel_stop(decel_stop), .setpoint(setpoint), .pos_err(pos_err),
        .move_done(move_done), .homing_done(homing_done),
        .axis_halted(axis_halted), .actual_pos(actual_pos));

    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
        input string what);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s %h vs %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic logic sw(input int b);
        return status_telegram[16 + b];
    endfunction : sw

    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        while (sw(b) !== v && n < 500)
        begin
            @(posedge aclk);
            n++;
        end
    endtask : wait_bit

    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            aw_ok = aw_ok || awready;
            w_ok = w_ok || wready;
            awvalid <= !aw_ok;
            wvalid <= !w_ok;
        end
        while (!(aw_ok && w_ok));
        do @(posedge aclk); while (!bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic send(input logic [15:0] c, input logic [31:0] t);
        wr(pci_pkg::ADDR_TX_LO, {c, 16'h0000});
        wr(pci_pkg::ADDR_TX_HI, t);
        wr(pci_pkg::ADDR_CTRL, 32'h0000_0001);
        repeat (4) @(posedge aclk);
    endtask : send

    task automatic mv(input logic [15:0] m, input logic [31:0] t);
        send(EN | m, t);
        send(EN | m | TRIG, t);
    endtask : mv

    task automatic t_regs();
        chk(status_telegram, 0, "idle status");
        rd(pci_pkg::ADDR_WINDOW);
        chk(rd_data, pci_pkg::RST_WINDOW, "window reset");
        rd(8'h1c);
        chk(resp, pci_pkg::RESP_SLVERR, "unmapped read");
        chk(rd_data, 0, "unmapped data");
        wr(8'h1c, 32'h0000_0001);
        chk(resp, pci_pkg::RESP_SLVERR, "unmapped write");
    endtask : t_regs

    task automatic t_enable();
        send(EN, 32'h0000_0000);
        chk(drive_enable, 1, "enable");
        chk(sw(pci_pkg::SW_POWER), 1, "power bit");
        chk(setpoint, actual_pos, "hold position");
        chk(motion_run, 0, "no motion");
        chk({status_telegram[63:32], status_telegram[15:0]}, 0,
            "lanes");
    endtask : t_enable

    task automatic t_homing();
        send(EN | HOME, 32'h0000_0000);
        chk(homing_run, 1, "homing start");
        send(EN | HOME | TRIG, 32'h0000_0500);
        send(EN | HOME | TRIG | PAUSE | HOLD, 32'h0000_0500);
        chk(motion_run, 0, "trigger in homing");
        chk(decel_stop, 0, "hold in homing");
        chk(sw(pci_pkg::SW_PAUSED), 0, "pause in homing");
        send(EN, 32'h0000_0000);
        chk(homing_run, 0, "homing abort");
        chk(drive_enable, 1, "abort without error");
        send(EN | HOME, 32'h0000_0000);
        wait_bit(pci_pkg::SW_HOME_OK, 1'b1);
        chk(sw(pci_pkg::SW_HOME_OK), 1, "home valid");
        send(EN, 32'h0000_0000);
    endtask : t_homing

    task automatic t_abs_rel();
        mv(16'h0000, 32'h0000_0100);
        chk(setpoint, 32'h0000_0100, "absolute");
        chk(motion_run, 1, "rise accepts");
        wait_bit(pci_pkg::SW_TARGET, 1'b1);
        chk(sw(pci_pkg::SW_TARGET), 1, "reached");
        send(EN | TRIG | REL, 32'h0000_0050);
        chk(setpoint, 32'h0000_0100, "select without edge");
        wr(pci_pkg::ADDR_TX_HI, 32'h0000_0999);
        rd(pci_pkg::ADDR_CMD_POS);
        chk(rd_data, 32'h0000_0050, "uncommitted target");
        send(EN, 32'h0000_0777);
        chk(setpoint, 32'h0000_0100, "fall ignored");
        chk(motion_run, 0, "fall no move");
        send(EN | TRIG | REL, 32'h0000_0050);
        chk(setpoint, 32'h0000_0150, "relative");
        wait_bit(pci_pkg::SW_TARGET, 1'b1);
    endtask : t_abs_rel

    task automatic t_append();
        mv(16'h0000, 32'h0000_1000);
        mv(16'h0000, 32'h0000_2000);
        chk(sw(pci_pkg::SW_QUEUED), 1, "queued");
        chk(setpoint, 32'h0000_1000, "first kept");
        wait_bit(pci_pkg::SW_QUEUED, 1'b0);
        chk(setpoint, 32'h0000_2000, "second runs");
        chk(sw(pci_pkg::SW_TARGET), 0, "no early reach");
        wait_bit(pci_pkg::SW_TARGET, 1'b1);
        chk(sw(pci_pkg::SW_TARGET), 1, "late reach");
    endtask : t_append

    task automatic t_preempt();
        mv(16'h0000, 32'h0000_3000);
        mv(PRE, 32'h0000_0400);
        chk(setpoint, 32'h0000_0400, "replaced");
        chk(sw(pci_pkg::SW_QUEUED), 0, "not queued");
        wait_bit(pci_pkg::SW_TARGET, 1'b1);
        chk(actual_pos, 32'h0000_0400, "new end");
    endtask : t_preempt

    task automatic t_pause();
        mv(16'h0000, 32'h0000_5000);
        send(EN | TRIG | PAUSE, 32'h0000_5000);
        chk(motion_run, 0, "paused");
        chk(sw(pci_pkg::SW_PAUSED), 1, "paused bit");
        repeat (120) @(posedge aclk);
        chk(sw(pci_pkg::SW_TARGET), 0, "still pending");
        send(EN | TRIG, 32'h0000_5000);
        chk(motion_run, 1, "resumed");
        wait_bit(pci_pkg::SW_TARGET, 1'b1);
        chk(actual_pos, 32'h0000_5000, "completed");
    endtask : t_pause

    task automatic t_hold();
        mv(16'h0000, 32'h0000_6000);
        send(EN | TRIG | HOLD, 32'h0000_6000);
        chk(decel_stop, 1, "hold stop");
        while (decel_stop !== 1'b0) @(posedge aclk);
        chk(sw(pci_pkg::SW_TARGET), 0, "no reach after hold");
        chk(sw(pci_pkg::SW_HELD), 1, "held flag");
        send(EN | TRIG, 32'h0000_6000);
        repeat (120) @(posedge aclk);
        chk(motion_run, 0, "no resume");
        chk(sw(pci_pkg::SW_TARGET), 0, "still not reached");
    endtask : t_hold

    // The window holds its reset width, so an error of that size is inside.
    task automatic t_window();
        pos_err <= 32'h0000_0020;
        mv(16'h0000, 32'h0000_7000);
        wait_bit(pci_pkg::SW_MOVING, 1'b0);
        chk(sw(pci_pkg::SW_TARGET), 0, "outside window");
        pos_err <= 32'h0000_0010;
        mv(16'h0000, 32'h0000_7100);
        wait_bit(pci_pkg::SW_MOVING, 1'b0);
        chk(sw(pci_pkg::SW_TARGET), 1, "window edge");
        send(16'h0000, 32'h0000_0000);
        chk(drive_enable, 0, "disable");
        chk(sw(pci_pkg::SW_POWER), 0, "power off");
        send(EN, 32'h0000_0000);
        chk(setpoint, 32'h0000_7110, "hold after enable");
    endtask : t_window

    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        pos_err = 32'h0000_0000;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_enable();
        t_homing();
        t_abs_rel();
        t_append();
        t_preempt();
        t_pause();
        t_hold();
        t_window();
        complete_run();
    end

    initial
    begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        complete_run();
    end
endmodule : positioning_command_interface_tb
`default_nettype wire
